// ### pipelined_burst_sram_core.sv
`timescale 1ns/10ps
`default_nettype none

module pipelined_burst_sram_core (
  input  wire logic                                sys_clk_in,
  input  wire logic                                resetn_in,
  input  wire logic                                clock_qualifier_n_in,
  input  wire logic                                chip_select1_n_in,
  input  wire logic                                chip_select2_in,
  input  wire logic                                chip_select3_n_in,
  input  wire logic                                advance_load_in,
  input  wire logic                                write_strobe_n_in,
  input  wire logic [burst_sram_pkg::LANES-1:0]    byte_lane_select_n_in,
  input  wire logic [burst_sram_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic                                out_drive_en_n_in,
  input  wire logic                                burst_order_in,
  input  wire logic                                sleep_request_in,
  input  wire logic [burst_sram_pkg::DATA_W-1:0]   dq_in,
  output logic      [burst_sram_pkg::DATA_W-1:0]   dq_out,
  output logic                                     dq_oe_out,
  output logic                                     wbuf_ready_out,
  output logic                                     sleep_active_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [burst_sram_pkg::BURST_W-1:0] burst_low(
    input logic [burst_sram_pkg::BURST_W-1:0] start,
    input logic [burst_sram_pkg::BURST_W-1:0] step,
    input logic                               order
  );
    if (order == burst_sram_pkg::ORDER_INTERLEAVED) begin
      burst_low = start ^ step;
    end else begin
      burst_low = start + step;
    end
  endfunction

  function automatic logic [burst_sram_pkg::DATA_W-1:0] merge_lanes(
    input logic [burst_sram_pkg::DATA_W-1:0] old_word,
    input logic [burst_sram_pkg::DATA_W-1:0] new_word,
    input logic [burst_sram_pkg::LANES-1:0]  lane_n
  );
    merge_lanes = old_word;
    for (int i = 0; i < burst_sram_pkg::LANES; i++) begin
      if (!lane_n[i]) begin
        merge_lanes[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
          new_word[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [burst_sram_pkg::DATA_W-1:0]  mem [burst_sram_pkg::WORDS];
  burst_sram_pkg::op_e                op_ff;
  burst_sram_pkg::sleep_e             sleep_ff;
  burst_sram_pkg::sleep_e             nxt_sleep;
  logic [burst_sram_pkg::ADDR_W-1:0]  addr_ff;
  logic [burst_sram_pkg::BURST_W-1:0] burst_cnt_ff;
  logic [burst_sram_pkg::LANES-1:0]   lane_n_ff;
  logic [burst_sram_pkg::DATA_W-1:0]  dq_ff;
  logic                               rd_valid_ff;
  logic                               order_ff;
  logic                               strap_taken_ff;
  logic                               awake;
  logic                               edge_en;
  logic                               selected;
  logic                               sleep_req;
  logic [burst_sram_pkg::ADDR_W-1:0]  cur_addr;
  logic [burst_sram_pkg::DATA_W-1:0]  rd_word;
  burst_sram_pkg::wr_entry_s          wr_entry;
  burst_sram_pkg::wr_entry_s          head;
  logic [burst_sram_pkg::ENTRY_W-1:0] head_bits;
  logic                               wbuf_push;
  logic                               wbuf_in_ready;
  logic                               wbuf_head_valid;
  logic                               wbuf_pop;

  // ----------------------------------------------------------------
  // qualification
  // ----------------------------------------------------------------
  assign selected  = !chip_select1_n_in && chip_select2_in && !chip_select3_n_in;
  assign sleep_req = (sleep_request_in == 1'b1);
  assign awake     = (sleep_ff == burst_sram_pkg::SLP_AWAKE);
  // a full write buffer holds the edge like the qualifier does
  assign edge_en   = !clock_qualifier_n_in && awake && wbuf_in_ready;
  assign cur_addr  = {addr_ff[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::BURST_W],
                      burst_low(addr_ff[burst_sram_pkg::BURST_W-1:0], burst_cnt_ff,
                                order_ff)};

  // ----------------------------------------------------------------
  // burst order strap, caught after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_taken_ff <= 1'b0;
      order_ff       <= burst_sram_pkg::ORDER_LINEAR;
    end else if (!strap_taken_ff) begin
      strap_taken_ff <= 1'b1;
      order_ff       <= burst_order_in;
    end
  end

  // ----------------------------------------------------------------
  // address, operation and burst counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_ff        <= burst_sram_pkg::OP_IDLE;
      addr_ff      <= burst_sram_pkg::ADDR_RST;
      burst_cnt_ff <= burst_sram_pkg::BURST_RST;
      lane_n_ff    <= burst_sram_pkg::LANES_OFF;
    end else if (!awake) begin
      op_ff <= burst_sram_pkg::OP_IDLE;
    end else if (edge_en) begin
      lane_n_ff <= byte_lane_select_n_in;
      if (!advance_load_in) begin
        if (selected) begin
          addr_ff      <= addr_in;
          burst_cnt_ff <= burst_sram_pkg::BURST_RST;
          op_ff        <= write_strobe_n_in ? burst_sram_pkg::OP_READ
                                            : burst_sram_pkg::OP_WRITE;
        end else begin
          op_ff <= burst_sram_pkg::OP_IDLE;
        end
      end else begin
        // selects and strobe ignored, type kept
        burst_cnt_ff <= burst_cnt_ff + burst_sram_pkg::BURST_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep sequencing, two clocks each way
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sleep = sleep_ff;
    case (sleep_ff)
      burst_sram_pkg::SLP_AWAKE:  if (sleep_req) nxt_sleep = burst_sram_pkg::SLP_ENTER;
      burst_sram_pkg::SLP_ENTER:  nxt_sleep = sleep_req ? burst_sram_pkg::SLP_ASLEEP
                                                        : burst_sram_pkg::SLP_AWAKE;
      burst_sram_pkg::SLP_ASLEEP: if (!sleep_req) nxt_sleep = burst_sram_pkg::SLP_EXIT;
      burst_sram_pkg::SLP_EXIT:   nxt_sleep = sleep_req ? burst_sram_pkg::SLP_ASLEEP
                                                        : burst_sram_pkg::SLP_AWAKE;
      default:                    nxt_sleep = burst_sram_pkg::SLP_AWAKE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sleep_ff <= burst_sram_pkg::SLP_AWAKE;
    end else begin
      sleep_ff <= nxt_sleep;
    end
  end

  assign sleep_active_out = (sleep_ff == burst_sram_pkg::SLP_ASLEEP);

  // ----------------------------------------------------------------
  // write buffer and self-timed array write
  // ----------------------------------------------------------------
  assign wr_entry  = '{addr: cur_addr, data: dq_in, lane_n: lane_n_ff};
  assign wbuf_push = edge_en && (op_ff == burst_sram_pkg::OP_WRITE);
  assign head      = burst_sram_pkg::wr_entry_s'(head_bits);
  // draining pauses while asleep
  assign wbuf_pop  = wbuf_head_valid && (sleep_ff != burst_sram_pkg::SLP_ASLEEP);
  assign wbuf_ready_out = wbuf_in_ready;

  write_fifo #(
    .WIDTH (burst_sram_pkg::ENTRY_W),
    .DEPTH (burst_sram_pkg::WBUF_DEPTH)
  ) u_wbuf (
    .sys_clk_in    (sys_clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (wbuf_push),
    .in_ready_out  (wbuf_in_ready),
    .in_data_in    (wr_entry),
    .out_valid_out (wbuf_head_valid),
    .out_ready_in  (wbuf_pop),
    .out_data_out  (head_bits)
  );

  always_ff @(posedge sys_clk_in) begin
    if (wbuf_pop) begin
      mem[head.addr] <= merge_lanes(mem[head.addr], head.data, head.lane_n);
    end
  end

  // the word still in the buffer is newer than the array
  always_comb begin
    rd_word = mem[cur_addr];
    if (wbuf_head_valid && (head.addr == cur_addr)) begin
      rd_word = merge_lanes(rd_word, head.data, head.lane_n);
    end
  end

  // ----------------------------------------------------------------
  // output register and drivers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_ff       <= burst_sram_pkg::DATA_RST;
      rd_valid_ff <= 1'b0;
    end else if (!awake) begin
      rd_valid_ff <= 1'b0;
    end else if (edge_en) begin
      rd_valid_ff <= (op_ff == burst_sram_pkg::OP_READ);
      if (op_ff == burst_sram_pkg::OP_READ) begin
        dq_ff <= rd_word;
      end
    end
  end

  assign dq_out    = dq_ff;
  assign dq_oe_out = rd_valid_ff && (op_ff != burst_sram_pkg::OP_WRITE)
                     && !out_drive_en_n_in;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  a_hold_when_idle: assert property (
    (awake && clock_qualifier_n_in) |=> $stable(addr_ff) && $stable(burst_cnt_ff)
      && $stable(op_ff) && $stable(dq_ff))
    else $error("state moved on a disqualified edge");

  a_load_address: assert property (
    (edge_en && selected && !advance_load_in) |=> addr_ff == $past(addr_in)
      && burst_cnt_ff == burst_sram_pkg::BURST_RST)
    else $error("address not latched on load");

  a_load_type: assert property (
    (edge_en && selected && !advance_load_in) |=>
      op_ff == ($past(write_strobe_n_in) ? burst_sram_pkg::OP_READ : burst_sram_pkg::OP_WRITE))
    else $error("access type does not follow write strobe");

  a_read_to_output: assert property (
    (edge_en && op_ff == burst_sram_pkg::OP_READ) |=> rd_valid_ff && dq_out == $past(rd_word))
    else $error("read data missing after read edge");

  a_deselect_tristate: assert property (
    (edge_en && op_ff == burst_sram_pkg::OP_IDLE) |=> !dq_oe_out)
    else $error("outputs still driven after deselect");

  a_burst_step: assert property (
    (edge_en && advance_load_in) |=> burst_cnt_ff == $past(burst_cnt_ff) + 2'h1
      && op_ff == $past(op_ff))
    else $error("burst advance wrong");

  a_burst_order: assert property (
    (order_ff == burst_sram_pkg::ORDER_INTERLEAVED) |->
      cur_addr[1:0] == (addr_ff[1:0] ^ burst_cnt_ff))
    else $error("interleaved burst address wrong");

  a_oe_async: assert property (
    out_drive_en_n_in |-> !dq_oe_out)
    else $error("drivers on with output enable high");

  a_write_phase_off: assert property (
    (op_ff == burst_sram_pkg::OP_WRITE) |-> !dq_oe_out)
    else $error("drivers on during write data phase");

  a_write_buffered: assert property (
    wbuf_push |=> wbuf_head_valid)
    else $error("write lost before buffer");

  a_sleep_entry: assert property (
    (awake && sleep_req) ##1 sleep_req |=> sleep_active_out)
    else $error("sleep not entered in two clocks");

  a_deselect_op: assert property (
    (edge_en && !selected && !advance_load_in) |=> op_ff == burst_sram_pkg::OP_IDLE)
    else $error("deselect did not end the access");

  a_freeze_misc: assert property (
    (awake && clock_qualifier_n_in) |=> $stable(lane_n_ff) && $stable(rd_valid_ff))
    else $error("inputs taken on a disqualified edge");

  a_lane_capture: assert property (
    edge_en |=> lane_n_ff == $past(byte_lane_select_n_in))
    else $error("byte lanes not captured");

  a_linear_step: assert property (
    (edge_en && advance_load_in && strap_taken_ff
      && order_ff == burst_sram_pkg::ORDER_LINEAR) |=>
      cur_addr[1:0] == $past(cur_addr[1:0]) + 2'h1)
    else $error("linear burst did not count up by one");

  a_reload_addr: assert property (
    (edge_en && selected && !advance_load_in) |=> cur_addr == $past(addr_in))
    else $error("load did not restart the burst");

  a_upper_fixed: assert property (
    (edge_en && advance_load_in) |=>
      cur_addr[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::BURST_W]
        == $past(cur_addr[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::BURST_W]))
    else $error("burst touched more than two address bits");

  a_burst_wrap: assert property (
    (edge_en && advance_load_in && burst_cnt_ff == 2'h3) |=> cur_addr == addr_ff)
    else $error("burst did not wrap after four accesses");

  a_oe_follows: assert property (
    (rd_valid_ff && op_ff == burst_sram_pkg::OP_READ && !out_drive_en_n_in) |-> dq_oe_out)
    else $error("drivers off although read data stands");

  a_back_to_back: assert property (
    (edge_en && op_ff == burst_sram_pkg::OP_READ && selected && !advance_load_in) |=>
      op_ff != burst_sram_pkg::OP_IDLE && rd_valid_ff)
    else $error("operation after read not taken");

  a_sleep_drops: assert property (
    !awake |=> op_ff == burst_sram_pkg::OP_IDLE && !dq_oe_out)
    else $error("access survived sleep entry");

  a_wake_up: assert property (
    (sleep_active_out && !sleep_req) ##1 !sleep_req |=> awake)
    else $error("sleep not left in two clocks");

  a_dq_registered: assert property (
    !edge_en |=> $stable(dq_out))
    else $error("read data changed without a qualified edge");

  a_strap_fixed: assert property (
    strap_taken_ff |=> $stable(order_ff))
    else $error("burst order changed after reset");

  a_write_drain: assert property (
    (wbuf_pop && !wbuf_push) |=> !wbuf_head_valid)
    else $error("buffered write not completed");

  c_read_back_to_back: cover property (
    edge_en && op_ff == burst_sram_pkg::OP_READ && selected && !advance_load_in);
  c_write_done: cover property (wbuf_pop);
  c_full_burst: cover property (
    edge_en && advance_load_in && burst_cnt_ff == 2'h3 && op_ff != burst_sram_pkg::OP_IDLE);
  c_sleep: cover property (sleep_active_out ##1 !sleep_req);
  c_read_deselect: cover property (
    edge_en && !selected && !advance_load_in && op_ff == burst_sram_pkg::OP_READ);

endmodule // pipelined_burst_sram_core

`default_nettype wire

// ### burst_sram_pkg.sv
package burst_sram_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 19;
  localparam int unsigned LANES     = 4;
  localparam int unsigned LANE_W    = 9;
  localparam int unsigned DATA_W    = LANES * LANE_W;
  localparam int unsigned WORDS     = 1 << ADDR_W;
  localparam int unsigned BURST_W   = 2;
  localparam int unsigned WBUF_DEPTH = 4;

  // ----------------------------------------------------------------
  // reset values and strap encodings
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 19'h00000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 36'h000000000;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [LANES-1:0]   LANES_OFF = 4'hF;
  localparam logic               ORDER_LINEAR      = 1'b0;
  localparam logic               ORDER_INTERLEAVED = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_e;

  typedef enum logic [1:0] {
    SLP_AWAKE,
    SLP_ENTER,
    SLP_ASLEEP,
    SLP_EXIT
  } sleep_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  lane_n;
  } wr_entry_s;

  localparam int unsigned ENTRY_W = $bits(wr_entry_s);

endpackage

// ### write_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module write_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] slot_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_ff != FULL_CNT);
  assign out_valid_out = (count_ff != '0);
  assign out_data_out  = slot_ff[rd_ptr_ff];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      slot_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule // write_fifo

`default_nettype wire

// ### sram_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_model #(
  parameter int unsigned AW = burst_sram_pkg::ADDR_W,
  parameter int unsigned DW = burst_sram_pkg::DATA_W,
  parameter int unsigned LN = burst_sram_pkg::LANES
) (
  input  wire logic          sys_clk_in,
  input  wire logic [DW-1:0] bus_q_in,
  input  wire logic          bus_oe_in,
  output logic               clock_qualifier_n_out,
  output logic               chip_select1_n_out,
  output logic               chip_select2_out,
  output logic               chip_select3_n_out,
  output logic               advance_load_out,
  output logic               write_strobe_n_out,
  output logic [LN-1:0]      byte_lane_select_n_out,
  output logic [AW-1:0]      addr_out,
  output logic               out_drive_en_n_out,
  output logic [DW-1:0]      bus_d_out
);
  logic [DW-1:0] wdat;
  logic [DW-1:0] last;
  logic          wdrv;

  initial begin
    clock_qualifier_n_out = 1'b1;
    chip_select1_n_out = 1'b1;
    chip_select2_out = 1'b0;
    chip_select3_n_out = 1'b1;
    advance_load_out = 1'b0;
    write_strobe_n_out = 1'b1;
    byte_lane_select_n_out = '1;
    addr_out = '0;
    out_drive_en_n_out = 1'b0;
    wdat = '0;
    last = '0;
    wdrv = 1'b0;
  end

  // --------------------------------
  // shared data wire
  // --------------------------------
  // nobody driving: inverse of last level
  always_comb begin
    if (bus_oe_in)
      bus_d_out = bus_q_in;
    else if (wdrv)
      bus_d_out = wdat;
    else
      bus_d_out = ~last;
  end

  always @(posedge sys_clk_in)
    last <= bus_d_out;

  // --------------------------------
  // pin drivers
  // --------------------------------
  task automatic drive(input logic qn, input logic ad, input logic [2:0] sel,
                       input logic wen, input logic [LN-1:0] ln, input logic [AW-1:0] a,
                       input logic drv, input logic [DW-1:0] d);
    @(negedge sys_clk_in);
    clock_qualifier_n_out <= qn;
    chip_select1_n_out <= ~sel[0];
    chip_select2_out <= sel[1];
    chip_select3_n_out <= ~sel[2];
    advance_load_out <= ad;
    write_strobe_n_out <= wen;
    byte_lane_select_n_out <= ln;
    addr_out <= a;
    wdrv <= drv;
    wdat <= d;
  endtask

  task automatic enable_n(input logic v);
    out_drive_en_n_out = v;
  endtask
endmodule // sram_ctrl_model
`default_nettype wire

// ### test_pipelined_burst_sram_core.sv
`timescale 1ns/10ps
`default_nettype none
module test_pipelined_burst_sram_core;
  localparam int unsigned AW = burst_sram_pkg::ADDR_W;
  localparam int unsigned DW = burst_sram_pkg::DATA_W;

  logic          clk, rstn, strap, slp, oe, wrdy, sact;
  logic          qn, cs1n, cs2, cs3n, adv, wen, oen;
  logic [3:0]    ln;
  logic [AW-1:0] a;
  logic [DW-1:0] din, dq;
  int            n_mismatch = 0;
  int            total_checks = 0;

  pipelined_burst_sram_core dut_u (
    .sys_clk_in(clk), .resetn_in(rstn), .clock_qualifier_n_in(qn),
    .chip_select1_n_in(cs1n), .chip_select2_in(cs2), .chip_select3_n_in(cs3n),
    .advance_load_in(adv), .write_strobe_n_in(wen), .byte_lane_select_n_in(ln),
    .addr_in(a), .out_drive_en_n_in(oen), .burst_order_in(strap),
    .sleep_request_in(slp), .dq_in(din), .dq_out(dq), .dq_oe_out(oe),
    .wbuf_ready_out(wrdy), .sleep_active_out(sact)
  );

  sram_ctrl_model m (
    .sys_clk_in(clk), .bus_q_in(dq), .bus_oe_in(oe), .clock_qualifier_n_out(qn),
    .chip_select1_n_out(cs1n), .chip_select2_out(cs2), .chip_select3_n_out(cs3n),
    .advance_load_out(adv), .write_strobe_n_out(wen), .byte_lane_select_n_out(ln),
    .addr_out(a), .out_drive_en_n_out(oen), .bus_d_out(din)
  );

  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [DW-1:0] pat(input logic [AW-1:0] x);
    return {x[DW-AW-1:0], x};
  endfunction

  function automatic logic [AW-1:0] seq(input logic [AW-1:0] s, input int i, input logic o);
    return {s[AW-1:2], o ? s[1:0] ^ 2'(i) : s[1:0] + 2'(i)};
  endfunction

  task automatic chk(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one qualified clock, outputs settled after it
  task automatic cy(input logic ad, input logic [2:0] s, input logic w, input logic [3:0] l,
                    input logic [AW-1:0] ar, input logic dr, input logic [DW-1:0] d);
    m.drive('0, ad, s, w, l, ar, dr, d);
    @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic o);
    @(negedge clk);
    rstn = 1'b0;
    strap = o;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset();
    chk("rst_oe", oe, 1'b0);
    chk("rst_dq", dq, '0);
    chk("rst_sleep", sact, 1'b0);
    chk("rst_wbuf", wrdy, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_burst(input logic o);
    logic [AW-1:0] b;
    logic [AW-1:0] r;
    b = 19'h2A5F2;
    r = {b[AW-1:2], 2'h1};
    cy('0, 3'h7, '0, 4'h0, b, '0, '0);
    for (int i = 0; i < 4; i++) begin
      if (i < 3)
        cy('1, 3'h0, '1, 4'h0, ~b, '1, pat(seq(b, i, o)));
      else
        cy('0, 3'h7, '1, 4'hF, r, '1, pat(seq(b, i, o)));
      chk("wr_oe", oe, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      if (i < 4)
        cy('1, 3'h0, '0, 4'hF, ~b, '0, '0);
      else
        cy('0, 3'h7, '1, 4'hF, b | 19'h3, '0, '0);
      chk("rd_data", dq, pat(seq(r, i, o)));
      chk("rd_oe", oe, 1'b1);
    end
    cy('0, 3'h0, '1, 4'hF, b, '0, '0);
    chk("rd_reload", dq, pat(b | 19'h3));
    cy('1, 3'h0, '1, 4'hF, b, '0, '0);
    chk("rd_off", oe, 1'b0);
    $display("test burst order %0d done", o);
  endtask

  task automatic t_lanes();
    logic [AW-1:0] b;
    b = 19'h13570;
    cy('0, 3'h7, '0, 4'h0, b, '0, '0);
    cy('0, 3'h7, '0, 4'h5, b, '1, pat(b));
    cy('0, 3'h7, '0, 4'hF, b, '1, ~pat(b));
    cy('0, 3'h0, '1, 4'hF, b, '1, '0);
    chk("wr_oe", oe, 1'b0);
    for (int i = 0; i < 3; i++) begin
      cy('0, 3'h7, '1, 4'hF, b, '0, '0);
      cy('0, 3'h7 ^ (3'h1 << i), '1, 4'hF, b, '0, '0);
      chk("lane_data", dq, pat(b) ^ 36'hFF803FE00);
      chk("ds_hold", oe, 1'b1);
      cy('1, 3'h0, '0, 4'hF, b, '0, '0);
      chk("ds_off", oe, 1'b0);
    end
    $display("test lanes done");
  endtask

  task automatic t_freeze();
    logic [AW-1:0] b;
    b = 19'h2A5F0;
    cy('0, 3'h7, '1, 4'hF, b, '0, '0);
    repeat (3) begin
      m.drive('1, '0, 3'h0, '0, 4'h0, ~b, '0, '0);
      @(posedge clk);
      #1;
      chk("frz_oe", oe, 1'b0);
    end
    cy('1, 3'h0, '0, 4'hF, ~b, '0, '0);
    chk("frz_data", dq, pat(b));
    m.drive('1, '0, 3'h0, '0, 4'hF, ~b, '0, '0);
    m.enable_n('1);
    #1;
    chk("oe_async_off", oe, 1'b0);
    m.enable_n('0);
    #1;
    chk("oe_async_on", oe, 1'b1);
    @(posedge clk);
    #1;
    chk("frz_hold", dq, pat(b));
    cy('0, 3'h0, '1, 4'hF, b, '0, '0);
    cy('1, 3'h0, '1, 4'hF, b, '0, '0);
    chk("frz_off", oe, 1'b0);
    $display("test freeze done");
  endtask

  task automatic t_sleep();
    logic [AW-1:0] b;
    b = 19'h2A5F3;
    @(negedge clk);
    slp = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("slp_on", sact, 1'b1);
    cy('0, 3'h7, '0, 4'h0, b, '0, '0);
    cy('1, 3'h0, '1, 4'h0, ~b, '1, '0);
    chk("slp_oe", oe, 1'b0);
    @(negedge clk);
    slp = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("slp_off", sact, 1'b0);
    cy('0, 3'h7, '1, 4'hF, b, '0, '0);
    cy('0, 3'h0, '1, 4'hF, b, '0, '0);
    chk("slp_keep", dq, pat(b));
    $display("test sleep done");
  endtask

  task automatic t_wbuf();
    logic [AW-1:0] b;
    b = 19'h0B0C4;
    cy('0, 3'h7, '0, 4'h0, b, '0, '0);
    cy('0, 3'h7, '1, 4'hF, b, '1, 36'h123456789);
    chk("wbuf_ready", wrdy, 1'b1);
    cy('0, 3'h0, '1, 4'hF, b, '0, '0);
    chk("wbuf_forward", dq, 36'h123456789);
    cy('1, 3'h0, '1, 4'hF, b, '0, '0);
    chk("wbuf_off", oe, 1'b0);
    $display("test write buffer done");
  endtask

  // --------------------------------
  // clock, sequence, watchdog
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    strap = 1'b0;
    slp = 1'b0;
    do_reset(1'b0);
    t_reset();
    t_burst(1'b0);
    t_lanes();
    t_freeze();
    t_sleep();
    do_reset(1'b1);
    t_burst(1'b1);
    t_wbuf();
    results();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    $display("mismatch watchdog expected finish seen hang");
    results();
  end
endmodule // test_pipelined_burst_sram_core
`default_nettype wire
